// File: bench/idoe_exec_chk.sv
`default_nettype none
module idoe_exec_chk (
    // Watched ports
    input wire logic core_clk, rst, instValid, destSel, fileWrEn, resultNullFlag, skipNext, busy,
    input wire logic [6:0] op, fileAddr, fileWrAddr,
    input wire logic [7:0] literal, fileRdData, fileWrData, acc
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Slot accepted, not discarded
    wire taken = instValid & ~busy;
    sequence s_skip; skipNext ##1 !skipNext; endsequence
    property p_orf; taken && op[5] && destSel |=> fileWrData == ($past(acc) | $past(fileRdData)); endproperty
    a_orf: assert property (p_orf) else $error("orf");
    property p_inc; taken && op[0] && !destSel |=> !fileWrEn && acc == $past(fileRdData) + 8'h01
        && resultNullFlag == (acc == 8'h00); endproperty
    a_inc: assert property (p_inc) else $error("inc");
    property p_dec; taken && op[1] |=> $stable(resultNullFlag) && skipNext == ($past(fileRdData) == 8'h01); endproperty
    a_dec: assert property (p_dec) else $error("dec");
    property p_skp; taken && op[1] && fileRdData == 8'h01 |=> s_skip; endproperty
    a_skp: assert property (p_skp) else $error("skp");
    property p_isk; taken && op[2] |=> $stable(resultNullFlag) && skipNext == ($past(fileRdData) == 8'hff); endproperty
    a_isk: assert property (p_isk) else $error("isk");
    property p_orl; taken && op[3] |=> acc == ($past(acc) | $past(literal)) && resultNullFlag == !acc; endproperty
    a_orl: assert property (p_orl) else $error("orl");
    property p_ldl; taken && op[4] |=> acc == $past(literal) && $stable(resultNullFlag); endproperty
    a_ldl: assert property (p_ldl) else $error("ldl");
    property p_sto; taken && op[6] |=> fileWrEn && fileWrData == $past(acc); endproperty
    a_sto: assert property (p_sto) else $error("sto");
    property p_wra; taken && (op[6] || destSel && (op[0] || op[1] || op[2] || op[5]))
        |=> fileWrEn && fileWrAddr == $past(fileAddr); endproperty
    a_wra: assert property (p_wra) else $error("wra");
    property p_drop; busy |=> !fileWrEn && $stable(acc) && $stable(resultNullFlag) && !skipNext; endproperty
    a_drop: assert property (p_drop) else $error("drop");
endmodule
bind idoe_exec idoe_exec_chk chk (.*);
`default_nettype wire

// File: bench/tb_idoe_exec.sv
`default_nettype none
module tb_idoe_exec;
    timeunit 1ns;
    timeprecision 1ps;
    // Stimulus, model state and observed ports
    logic core_clk = 0, rst = 1, instValid = 0, destSel = 0, d, v, mz = 0, mw = 0, ms = 0;
    logic [6:0] op = 7'h00, fileAddr = 7'h00, o, fa, wa;
    logic [7:0] literal = 8'h00, fileRdData = 8'h00, mem [128], l, f, r, ma = 8'h00;
    wire logic fileWrEn, resultNullFlag, skipNext, busy;
    wire logic [6:0] fileWrAddr;
    wire logic [7:0] fileWrData, acc;
    integer seed = 58, err_count = 0, checks = 0, i;
    idoe_exec dut (.*);
    initial forever #12.5 core_clk = ~core_clk;
    task chk(input string n, input logic [7:0] e, g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task final_report;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Operands from 00, 01, fe, ff so zero, wrap and skip come up often
    function logic [7:0] pick(input integer x);
        return {8{x[0]}} ^ {7'h00, x[1]};
    endfunction
    // Run is about 620 cycles; double it
    initial
    begin
        #30000;
        err_count++;
        final_report;
    end
    initial
    begin
        for (i = 0; i < 128; i++)
            mem[i] = pick($random(seed));
        repeat (16) @(posedge core_clk);
        rst <= 0;
        repeat (600)
        begin
            @(posedge core_clk);
            o = 7'h01 << ($unsigned($random(seed)) % 7);
            fa = 7'($random(seed));
            d = 1'($random(seed));
            v = $random(seed) % 8 != 0;
            l = pick($random(seed));
            {instValid, op, fileAddr, destSel, literal, fileRdData} <= {v, o, fa, d, l, mem[fa]};
            #1;
            chk("wren", mw, fileWrEn);
            if (mw) chk("wraddr", wa, fileWrAddr);
            if (mw) chk("wrdata", r, fileWrData);
            chk("acc", ma, acc);
            chk("flag", mz, resultNullFlag);
            chk("skip", ms, skipNext);
            chk("busy", ms, busy);
            // Discarded or idle slot changes nothing
            if (ms || !v)
                {ms, mw} = 2'h0;
            else
            begin
                f = mem[fa];
                r = o[1] ? f - 8'h01 : (o[0] | o[2]) ? f + 8'h01 : o[3] ? ma | l : o[4] ? l : o[5] ? ma | f : ma;
                mw = o[6] | (d & (o[0] | o[1] | o[2] | o[5]));
                wa = fa;
                if (mw) mem[fa] = r;
                if (o[3] | o[4] | (!d & !o[6])) ma = r;
                if (o[0] | o[3] | o[5]) mz = r == 8'h00;
                ms = (o[1] | o[2]) && r == 8'h00;
            end
        end
        final_report;
    end
endmodule
`default_nettype wire

// File: logic/idoe_alu.v
`default_nettype none
`include "idoe_exec_regs.vh"
// Combinational result and zero detection
module idoe_alu #(
    parameter DW = 8
) (
    // Operation and operands
    input wire [`IDOE_OP_W-1:0] op,
    input wire [DW-1:0] accIn,
    input wire [DW-1:0] fileIn,
    input wire [DW-1:0] literal,
    // Results
    output reg [DW-1:0] result,
    output wire resultZero
);

    ////////////////////////////////////////////////////////////////////////
    // Result select; sums wrap because the width is fixed
    always @*
    begin
        case (op)
            `IDOE_OP_INC_FILE: result = fileIn + `IDOE_ONE_BYTE;
            `IDOE_OP_INC_SKIP_ZERO: result = fileIn + `IDOE_ONE_BYTE;
            `IDOE_OP_DEC_SKIP_ZERO: result = fileIn - `IDOE_ONE_BYTE;
            `IDOE_OP_OR_LITERAL_ACC: result = accIn | literal;
            `IDOE_OP_LOAD_LITERAL_ACC: result = literal;
            `IDOE_OP_OR_ACC_FILE: result = accIn | fileIn;
            `IDOE_OP_STORE_ACC_FILE: result = accIn;
            default: result = accIn;
        endcase
    end

    // Zero detect shared by flag and skip
    assign resultZero = (result == `IDOE_ZERO_BYTE);

endmodule
`default_nettype wire

// File: logic/idoe_exec.v
`default_nettype none
`include "idoe_exec_regs.vh"
// Timing in brief: an instruction presented with instValid high is
// taken at the rising edge, and its results show one cycle later.
// The file register array lives outside; fileRdData must already
// carry the word at fileAddr in the cycle the instruction is taken.
// A skip instruction with a zero result closes the following slot,
// so whatever the decoder presents there is dropped, not executed.
// Limitation: a write and a read of one address in adjacent slots
// rely on the outside array forwarding the fresh word.
module idoe_exec #(
    parameter DW = 8,
    parameter AW = 7
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Decoded instruction, one per instruction cycle
    input wire instValid,
    input wire [`IDOE_OP_W-1:0] op,
    input wire [AW-1:0] fileAddr,
    input wire destSel,
    input wire [DW-1:0] literal,
    // File register read data for fileAddr
    input wire [DW-1:0] fileRdData,
    // File register write port
    output reg fileWrEn,
    output reg [AW-1:0] fileWrAddr,
    output reg [DW-1:0] fileWrData,
    // Architectural state
    output reg [DW-1:0] acc,
    output reg resultNullFlag,
    // Skip indication: next instruction is a no-operation
    output reg skipNext,
    output wire busy
);

    ////////////////////////////////////////////////////////////////////////
    // States, one-hot
    localparam ST_EXEC = 2'b01;
    localparam ST_NOP = 2'b10;

    reg [1:0] state; // Current state
    reg [1:0] next_state; // Next state
    wire [DW-1:0] result; // ALU result
    wire resultZero; // Result equals zero
    wire take; // Instruction executed this cycle
    reg writesFile; // Result goes to file register
    reg writesAcc; // Result goes to accumulator
    reg setsFlag; // Instruction updates the zero flag
    reg skipOp; // Skip-capable instruction
    wire skipNow; // Zero result of a taken skip instruction

    ////////////////////////////////////////////////////////////////////////
    // Shared ALU
    idoe_alu #(
        .DW(DW)
    ) uAlu (
        .op(op),
        .accIn(acc),
        .fileIn(fileRdData),
        .literal(literal),
        .result(result),
        .resultZero(resultZero)
    );

    // Instruction in the skipped slot is dropped, not executed
    assign take = instValid && (state == ST_EXEC);
    assign busy = (state == ST_NOP);

    ////////////////////////////////////////////////////////////////////////
    // Per-instruction attributes, one branch per one-hot code.
    // A table like this keeps the destination rules in one place, at
    // the cost of a few more lines than a sum-of-products decode.
    always @*
    begin
        // Defaults: no write, flag and skip untouched
        writesFile = 1'b0;
        writesAcc = 1'b0;
        setsFlag = 1'b0;
        skipOp = 1'b0;
        case (op)
            `IDOE_OP_INC_FILE:
            begin
                // Destination bit decides, flag follows result
                writesFile = (destSel == `IDOE_DEST_FILE);
                writesAcc = (destSel == `IDOE_DEST_ACC);
                setsFlag = 1'b1;
            end
            `IDOE_OP_DEC_SKIP_ZERO:
            begin
                // No flag; zero result closes the next slot
                writesFile = (destSel == `IDOE_DEST_FILE);
                writesAcc = (destSel == `IDOE_DEST_ACC);
                skipOp = 1'b1;
            end
            `IDOE_OP_INC_SKIP_ZERO:
            begin
                // As the decrement form, but counting up
                writesFile = (destSel == `IDOE_DEST_FILE);
                writesAcc = (destSel == `IDOE_DEST_ACC);
                skipOp = 1'b1;
            end
            `IDOE_OP_OR_LITERAL_ACC:
            begin
                // Literal forms always land in the accumulator
                writesAcc = 1'b1;
                setsFlag = 1'b1;
            end
            `IDOE_OP_LOAD_LITERAL_ACC:
            begin
                // Plain load leaves the flag alone
                writesAcc = 1'b1;
            end
            `IDOE_OP_OR_ACC_FILE:
            begin
                // Destination bit decides, flag follows result
                writesFile = (destSel == `IDOE_DEST_FILE);
                writesAcc = (destSel == `IDOE_DEST_ACC);
                setsFlag = 1'b1;
            end
            `IDOE_OP_STORE_ACC_FILE:
            begin
                // Store has no destination bit; file only
                writesFile = 1'b1;
            end
            default:
            begin
                // Unknown codes copy the accumulator to the file
                // when the destination bit asks for the file
                writesFile = (destSel == `IDOE_DEST_FILE);
            end
        endcase
    end

    // Skip fires only for a taken instruction with a zero result
    assign skipNow = take && skipOp && resultZero;

    ////////////////////////////////////////////////////////////////////////
    // Next state: a zero skip result costs one extra cycle
    always @*
    begin
        case (state)
            ST_EXEC:
            begin
                if (skipNow)
                    next_state = ST_NOP;
                else
                    next_state = ST_EXEC;
            end
            ST_NOP: next_state = ST_EXEC; // Slot consumed as no-operation
            default: next_state = ST_EXEC;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Slot state; reset opens the next slot for execution
    always @(posedge core_clk)
    begin
        if (rst)
            state <= ST_EXEC;
        else
            state <= next_state;
    end

    // Registered skip mark, high during the dropped slot
    always @(posedge core_clk)
    begin
        if (rst)
            skipNext <= 1'b0;
        else
            skipNext <= (next_state == ST_NOP);
    end

    ////////////////////////////////////////////////////////////////////////
    // File write port; strobe lasts one cycle, address and data hold
    // until the next write so a slow array can still latch them
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            fileWrEn <= 1'b0;
            fileWrAddr <= {AW{1'b0}};
            fileWrData <= `IDOE_ZERO_BYTE;
        end
        else
        begin
            fileWrEn <= take && writesFile;
            if (take && writesFile)
            begin
                // Address is the one read this cycle
                fileWrAddr <= fileAddr;
                fileWrData <= result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator; store and file-destination forms leave it alone
    always @(posedge core_clk)
    begin
        if (rst)
            acc <= `IDOE_ACC_RESET;
        else if (take && writesAcc)
            acc <= result;
    end

    // Zero flag; ops that do not affect it simply hold it
    always @(posedge core_clk)
    begin
        if (rst)
            resultNullFlag <= `IDOE_FLAG_RESET;
        else if (take && setsFlag)
            resultNullFlag <= resultZero;
    end

endmodule
`default_nettype wire

// File: logic/idoe_exec_regs.vh
`ifndef IDOE_EXEC_REGS_VH
`define IDOE_EXEC_REGS_VH
// Operation codes presented by the decoder (one-hot)
`define IDOE_OP_W 7
`define IDOE_OP_INC_FILE 7'h01
`define IDOE_OP_DEC_SKIP_ZERO 7'h02
`define IDOE_OP_INC_SKIP_ZERO 7'h04
`define IDOE_OP_OR_LITERAL_ACC 7'h08
`define IDOE_OP_LOAD_LITERAL_ACC 7'h10
`define IDOE_OP_OR_ACC_FILE 7'h20
`define IDOE_OP_STORE_ACC_FILE 7'h40
// Destination select encoding
`define IDOE_DEST_ACC 1'h0
`define IDOE_DEST_FILE 1'h1
// Reset values and byte constants
`define IDOE_ACC_RESET 8'h00
`define IDOE_FLAG_RESET 1'h0
`define IDOE_ZERO_BYTE 8'h00
`define IDOE_ONE_BYTE 8'h01
`endif
